// ==== hw/tzfm_monitor.sv ====
// Thermistor zone classification, charge control and fault flags
`timescale 1ns/10ps
// What this block does
// - Thermistor above open threshold stops charging and sets the open flag.
// - Watchdog expiry rising edge sets watchdog flag; charging stays enabled.
// - Safety expiry sets flag, locks charging until supply/enable toggles; rerun after clear.
// - Button held low for wake one, wake two, reset warning sets three flags.
// - Power-good pin shows supply valid, or host output, or button copy.
// - Thermistor biased and sampled in 25 ms bursts every 225 ms.
// - Bias disable request ignored while the input supply is present.
// - Thermistor control selectable: four-zone, hot/cold only, or off.
// - Charging and safety timer suspended in hot or cold zone.
// - Cool zone cuts current by programmed fraction, rounded down to whole steps.
// - Warm zone lowers regulation voltage to the thermal charge setting.
// - Any thermistor fault, in every mode, gives one 128 us interrupt pulse.
// - Fault bits stay set until the host reads them; the safety flag also clears on a supply/enable toggle.
// - Interrupt on every threshold crossing; thresholds reprogrammable by host.
// - Measured thermistor voltage readable while supply or battery present.
// - Default thresholds: open 0.9, cold 0.585, cool 0.514, warm 0.265, hot 0.185 V.
module tzfm_monitor #(
  parameter int BURST_US  = tzfm_pkg::BURST_US,
  parameter int PERIOD_US = tzfm_pkg::PERIOD_US,
  parameter int WAKE1_MS  = 100,
  parameter int WAKE2_MS  = 500,
  parameter int RWARN_MS  = 2000
) (
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  input  wire logic                      supply_present,
  input  wire logic                      battery_present,
  input  wire logic [tzfm_pkg::TS_W-1:0] thermistor_sense_input,
  input  wire logic                      bias_disable_request,
  input  tzfm_pkg::tzfm_ts_mode_t        ts_mode,
  input  wire logic                      thr_write,
  input  wire logic [2:0]                thr_select,
  input  wire logic [tzfm_pkg::TS_W-1:0] thr_value,
  input  wire logic                      watchdog_expire,
  input  wire logic                      safety_timer_expire,
  input  wire logic                      charge_enable,
  input  wire logic                      push_button_input_n,
  input  wire logic                      fault_read,
  input  tzfm_pkg::tzfm_pg_mode_t        pg_mode,
  input  wire logic                      general_output_function,
  input  wire logic [7:0]                fast_charge_current_setting,
  input  wire logic [2:0]                cool_zone_current_fraction,
  input  wire logic [7:0]                battery_reg_setting,
  input  wire logic [7:0]                thermal_charge_setting,
  output logic                           ts_bias_enable,
  output logic                           charge_allow,
  output logic                           safety_timer_run,
  output logic [7:0]                     charge_current_out,
  output logic [7:0]                     reg_voltage_out,
  output logic                           interrupt_pulse,
  output logic [tzfm_pkg::TS_W-1:0]      ts_voltage_out,
  output logic                           ts_voltage_valid,
  output tzfm_pkg::tzfm_zone_t           ts_zone_out,
  output logic                           thermistor_open_flag,
  output logic                           thermistor_cold_flag,
  output logic                           thermistor_cool_flag,
  output logic                           thermistor_warm_flag,
  output logic                           thermistor_hot_flag,
  output logic                           watchdog_expired_flag,
  output logic                           safety_timer_expired_flag,
  output logic                           button_wake_one_flag,
  output logic                           button_wake_two_flag,
  output logic                           button_reset_warning_flag,
  output logic                           supply_valid_out,
  output logic                           supply_valid_out_oe
);
  localparam int PW = $clog2(PERIOD_US + 1);
  localparam int BW = 16;
  localparam int TW = tzfm_pkg::TS_W;

  typedef struct packed {
    logic [7:0]                          us_div;
    logic [9:0]                          ms_div;
    logic [PW-1:0]                       per_cnt;
    tzfm_pkg::tzfm_zone_t                zone;
    logic [TW-1:0]                       ts_volt;
    logic [tzfm_pkg::THR_N-1:0][TW-1:0]  thr;
    logic [tzfm_pkg::FLAG_N-1:0]         flags;
    logic [7:0]                          int_cnt;
    logic                                int_q;
    logic                                lock;
    logic                                vin_prev;
    logic                                ce_prev;
    logic                                wd_prev;
    logic                                exp_prev;
    logic [BW-1:0]                       btn_cnt;
    logic                                pg_oe;
    logic                                chg;
    logic                                run;
    logic [7:0]                          cur;
    logic [7:0]                          vreg;
  } tzfm_state_t;

  localparam tzfm_state_t ST_RST = '{
    zone:    tzfm_pkg::ZONE_NORMAL,
    thr:     {tzfm_pkg::THR_HOT_RST, tzfm_pkg::THR_WARM_RST, tzfm_pkg::THR_COOL_RST,
              tzfm_pkg::THR_COLD_RST, tzfm_pkg::THR_OPEN_RST},
    default: '0
  };

  tzfm_state_t s_q;
  tzfm_state_t s_d;

  // ****************************************
  // Zone classification
  // ****************************************
  function automatic tzfm_pkg::tzfm_zone_t classify(
    input logic [TW-1:0]                      v,
    input logic [tzfm_pkg::THR_N-1:0][TW-1:0] t
  );
    if (v > t[tzfm_pkg::THR_OPEN]) begin
      return tzfm_pkg::ZONE_OPEN;
    end else if (v > t[tzfm_pkg::THR_COLD]) begin
      return tzfm_pkg::ZONE_COLD;
    end else if (v > t[tzfm_pkg::THR_COOL]) begin
      return tzfm_pkg::ZONE_COOL;
    end else if (v < t[tzfm_pkg::THR_HOT]) begin
      return tzfm_pkg::ZONE_HOT;
    end else if (v < t[tzfm_pkg::THR_WARM]) begin
      return tzfm_pkg::ZONE_WARM;
    end
    return tzfm_pkg::ZONE_NORMAL;
  endfunction : classify

  logic                        us_tick;
  logic                        ms_tick;
  logic                        sampling_on;
  logic                        in_burst;
  logic                        burst_end;
  logic                        zone_event;
  logic                        pressed;
  logic                        wake1_hit;
  logic                        wake2_hit;
  logic                        rwarn_hit;
  logic                        toggle;
  logic                        exp_rise;
  logic [tzfm_pkg::FLAG_N-1:0] set_v;
  logic [tzfm_pkg::FLAG_N-1:0] clr_v;
  logic [11:0]                 cool_prod;
  tzfm_pkg::tzfm_zone_t        zone_new;
  tzfm_pkg::tzfm_zone_t        zone_eff;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_d         = s_q;
    us_tick     = (s_q.us_div == 8'(tzfm_pkg::TICK_CYCLES - 1));
    ms_tick     = us_tick && (s_q.ms_div == 10'(tzfm_pkg::US_PER_MS - 1));
    sampling_on = supply_present || battery_present;
    in_burst    = sampling_on && (s_q.per_cnt < PW'(BURST_US));
    burst_end   = sampling_on && us_tick && (s_q.per_cnt == PW'(BURST_US - 1));
    s_d.us_div  = us_tick ? 8'h00 : s_q.us_div + 8'h01;
    if (us_tick) begin
      s_d.ms_div = ms_tick ? 10'h000 : s_q.ms_div + 10'h001;
    end
    if (!sampling_on) begin
      s_d.per_cnt = '0;
    end else if (us_tick) begin
      s_d.per_cnt = (s_q.per_cnt == PW'(PERIOD_US - 1)) ? '0 : s_q.per_cnt + 1'b1;
    end
    if (thr_write && (thr_select < 3'(tzfm_pkg::THR_N))) begin
      s_d.thr[thr_select] = thr_value;
    end
    zone_new   = classify(thermistor_sense_input, s_q.thr);
    zone_event = burst_end && (zone_new != s_q.zone);
    if (burst_end) begin
      s_d.zone    = zone_new;
      s_d.ts_volt = thermistor_sense_input;
    end
    // Flag events
    set_v                       = '0;
    set_v[tzfm_pkg::FLG_OPEN]   = zone_event && (zone_new == tzfm_pkg::ZONE_OPEN);
    set_v[tzfm_pkg::FLG_COLD]   = zone_event && (zone_new == tzfm_pkg::ZONE_COLD);
    set_v[tzfm_pkg::FLG_COOL]   = zone_event && (zone_new == tzfm_pkg::ZONE_COOL);
    set_v[tzfm_pkg::FLG_WARM]   = zone_event && (zone_new == tzfm_pkg::ZONE_WARM);
    set_v[tzfm_pkg::FLG_HOT]    = zone_event && (zone_new == tzfm_pkg::ZONE_HOT);
    set_v[tzfm_pkg::FLG_WD]     = watchdog_expire && !s_q.wd_prev;
    exp_rise                    = safety_timer_expire && !s_q.exp_prev;
    set_v[tzfm_pkg::FLG_SAFETY] = exp_rise;
    pressed   = !push_button_input_n;
    wake1_hit = pressed && ms_tick && (s_q.btn_cnt == BW'(WAKE1_MS - 1));
    wake2_hit = pressed && ms_tick && (s_q.btn_cnt == BW'(WAKE2_MS - 1));
    rwarn_hit = pressed && ms_tick && (s_q.btn_cnt == BW'(RWARN_MS - 1));
    set_v[tzfm_pkg::FLG_WAKE1] = wake1_hit;
    set_v[tzfm_pkg::FLG_WAKE2] = wake2_hit;
    set_v[tzfm_pkg::FLG_RWARN] = rwarn_hit;
    if (!pressed) begin
      s_d.btn_cnt = '0;
    end else if (ms_tick && (s_q.btn_cnt != '1)) begin
      s_d.btn_cnt = s_q.btn_cnt + 1'b1;
    end
    toggle = (supply_present != s_q.vin_prev) || (charge_enable != s_q.ce_prev);
    clr_v  = fault_read ? '1 : '0;
    clr_v[tzfm_pkg::FLG_SAFETY] = fault_read || toggle;
    s_d.flags = set_v | (s_q.flags & ~clr_v);
    s_d.vin_prev = supply_present;
    s_d.ce_prev  = charge_enable;
    s_d.wd_prev  = watchdog_expire;
    s_d.exp_prev = safety_timer_expire;
    if (exp_rise) begin
      s_d.lock = 1'b1;
    end else if (toggle) begin
      s_d.lock = 1'b0;
    end
    // Interrupt pulse, restarted by every event
    // One extra count covers the part-used first microsecond
    if (zone_event || (|set_v)) begin
      s_d.int_cnt = 8'(tzfm_pkg::INT_PULSE_US + 1);
    end else if (us_tick && (s_q.int_cnt != 8'h00)) begin
      s_d.int_cnt = s_q.int_cnt - 8'h01;
    end
    s_d.int_q = (s_d.int_cnt != 8'h00);
    // Effective zone for charge control
    case (ts_mode)
      tzfm_pkg::TS_FOUR_ZONE: zone_eff = s_d.zone;
      tzfm_pkg::TS_HOT_COLD: begin
        if ((s_d.zone == tzfm_pkg::ZONE_COOL) || (s_d.zone == tzfm_pkg::ZONE_WARM)) begin
          zone_eff = tzfm_pkg::ZONE_NORMAL;
        end else begin
          zone_eff = s_d.zone;
        end
      end
      default: begin
        if (s_d.zone == tzfm_pkg::ZONE_OPEN) begin
          zone_eff = tzfm_pkg::ZONE_OPEN;
        end else begin
          zone_eff = tzfm_pkg::ZONE_NORMAL;
        end
      end
    endcase
    s_d.chg = charge_enable && supply_present && !s_d.lock &&
              (zone_eff != tzfm_pkg::ZONE_OPEN) && (zone_eff != tzfm_pkg::ZONE_COLD) &&
              (zone_eff != tzfm_pkg::ZONE_HOT);
    s_d.run = s_d.chg && !s_d.flags[tzfm_pkg::FLG_SAFETY];
    cool_prod = 12'(fast_charge_current_setting * (tzfm_pkg::FRAC_ONE -
                {1'b0, cool_zone_current_fraction}));
    s_d.cur = (zone_eff == tzfm_pkg::ZONE_COOL) ? cool_prod[tzfm_pkg::FRAC_SHIFT +: 8] :
              fast_charge_current_setting;
    s_d.vreg = (zone_eff == tzfm_pkg::ZONE_WARM) ? thermal_charge_setting :
               battery_reg_setting;
    // Open-drain pin, enable pulls low
    case (pg_mode)
      tzfm_pkg::PG_SUPPLY: s_d.pg_oe = supply_present;
      tzfm_pkg::PG_GPO:    s_d.pg_oe = !general_output_function;
      tzfm_pkg::PG_BUTTON: s_d.pg_oe = pressed;
      default:             s_d.pg_oe = supply_present;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= ST_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign ts_bias_enable = in_burst && (supply_present || !bias_disable_request);
  assign charge_allow              = s_q.chg;
  assign safety_timer_run          = s_q.run;
  assign charge_current_out        = s_q.cur;
  assign reg_voltage_out           = s_q.vreg;
  assign interrupt_pulse           = s_q.int_q;
  assign ts_voltage_out            = s_q.ts_volt;
  assign ts_voltage_valid          = sampling_on;
  assign ts_zone_out               = s_q.zone;
  assign thermistor_open_flag      = s_q.flags[tzfm_pkg::FLG_OPEN];
  assign thermistor_cold_flag      = s_q.flags[tzfm_pkg::FLG_COLD];
  assign thermistor_cool_flag      = s_q.flags[tzfm_pkg::FLG_COOL];
  assign thermistor_warm_flag      = s_q.flags[tzfm_pkg::FLG_WARM];
  assign thermistor_hot_flag       = s_q.flags[tzfm_pkg::FLG_HOT];
  assign watchdog_expired_flag     = s_q.flags[tzfm_pkg::FLG_WD];
  assign safety_timer_expired_flag = s_q.flags[tzfm_pkg::FLG_SAFETY];
  assign button_wake_one_flag      = s_q.flags[tzfm_pkg::FLG_WAKE1];
  assign button_wake_two_flag      = s_q.flags[tzfm_pkg::FLG_WAKE2];
  assign button_reset_warning_flag = s_q.flags[tzfm_pkg::FLG_RWARN];
  assign supply_valid_out          = 1'b0;
  assign supply_valid_out_oe       = s_q.pg_oe;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence open_entry_s;
    zone_event && (zone_new == tzfm_pkg::ZONE_OPEN);
  endsequence
  sequence expire_s;
    $rose(safety_timer_expire) && !toggle;
  endsequence

  open_flag_a: assert property (open_entry_s |=> thermistor_open_flag && !charge_allow)
    else $error("open entry did not flag or stop charging");
  wd_flag_a: assert property ($rose(watchdog_expire) |=> watchdog_expired_flag)
    else $error("watchdog edge not flagged");
  safety_lock_a: assert property (expire_s |=> !charge_allow && safety_timer_expired_flag)
    else $error("safety expiry did not lock charging");
  safety_run_a: assert property (safety_timer_expired_flag |-> !safety_timer_run)
    else $error("safety timer runs while flag set");
  wake_one_a: assert property (wake1_hit |=> button_wake_one_flag)
    else $error("wake one not flagged");
  bias_hold_a: assert property (supply_present && in_burst |-> ts_bias_enable)
    else $error("bias dropped while supply present");
  bias_burst_a: assert property (ts_bias_enable |-> s_q.per_cnt < PW'(BURST_US))
    else $error("bias outside burst");
  suspend_a: assert property ((ts_zone_out == tzfm_pkg::ZONE_HOT) &&
                              (int'($past(ts_mode)) < int'(tzfm_pkg::TS_OFF))
                              |-> !charge_allow && !safety_timer_run)
    else $error("charging in hot zone");
  int_pulse_a: assert property (zone_event |=> interrupt_pulse [*8])
    else $error("crossing gave no interrupt pulse");
  flag_hold_a: assert property (thermistor_cold_flag && !fault_read |=> thermistor_cold_flag)
    else $error("fault bit lost without read");
  zone_hold_a: assert property (!burst_end |=> $stable(ts_zone_out))
    else $error("zone changed between bursts");
endmodule : tzfm_monitor

// ==== hw/tzfm_pkg.sv ====
// Constants and types shared by the thermistor zone fault monitor
package tzfm_pkg;
  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int CLK_MHZ      = 200;
  localparam int TICK_CYCLES  = CLK_MHZ;
  localparam int US_PER_MS    = 1000;
  localparam int BURST_MS     = 25;
  localparam int PERIOD_MS    = 225;
  localparam int BURST_US     = BURST_MS * US_PER_MS;
  localparam int PERIOD_US    = PERIOD_MS * US_PER_MS;
  localparam int INT_PULSE_US = 128;
  // ****************************************
  // Thermistor voltage, millivolt codes
  // ****************************************
  localparam int TS_W = 10;
  localparam logic [TS_W-1:0] THR_OPEN_RST = 10'h384;
  localparam logic [TS_W-1:0] THR_COLD_RST = 10'h249;
  localparam logic [TS_W-1:0] THR_COOL_RST = 10'h202;
  localparam logic [TS_W-1:0] THR_WARM_RST = 10'h109;
  localparam logic [TS_W-1:0] THR_HOT_RST  = 10'h0B9;
  localparam logic [2:0] THR_OPEN = 3'h0;
  localparam logic [2:0] THR_COLD = 3'h1;
  localparam logic [2:0] THR_COOL = 3'h2;
  localparam logic [2:0] THR_WARM = 3'h3;
  localparam logic [2:0] THR_HOT  = 3'h4;
  localparam int THR_N = 5;
  // ****************************************
  // Flag positions
  // ****************************************
  localparam int FLG_OPEN   = 0;
  localparam int FLG_COLD   = 1;
  localparam int FLG_COOL   = 2;
  localparam int FLG_WARM   = 3;
  localparam int FLG_HOT    = 4;
  localparam int FLG_WD     = 5;
  localparam int FLG_SAFETY = 6;
  localparam int FLG_WAKE1  = 7;
  localparam int FLG_WAKE2  = 8;
  localparam int FLG_RWARN  = 9;
  localparam int FLAG_N     = 10;
  // ****************************************
  // Cool-zone current fraction in eighths
  // ****************************************
  localparam logic [3:0] FRAC_ONE   = 4'h8;
  localparam int         FRAC_SHIFT = 3;
  // ****************************************
  // Modes and zones
  // ****************************************
  typedef enum logic [1:0] {TS_FOUR_ZONE, TS_HOT_COLD, TS_OFF} tzfm_ts_mode_t;
  typedef enum logic [1:0] {PG_SUPPLY, PG_GPO, PG_BUTTON} tzfm_pg_mode_t;
  typedef enum logic [2:0] {
    ZONE_NORMAL, ZONE_OPEN, ZONE_COLD, ZONE_COOL, ZONE_WARM, ZONE_HOT
  } tzfm_zone_t;
endpackage : tzfm_pkg

// ==== tb/tzfm_monitor_tb.sv ====
// Self-checking bench for the thermistor zone fault monitor
`timescale 1ns/10ps
module tzfm_monitor_tb;
  // ****************************************
  // Signals and model state
  // ****************************************
  localparam int BUS = 5;
  localparam int PUS = 20;
  localparam int PER = PUS * tzfm_pkg::TICK_CYCLES;
  localparam int NS  = 12;
  logic                      clk = 1'b0, sys_rst = 1'b1, thr_write = 1'b0;
  logic                      supply_present = 1'b1, battery_present = 1'b1;
  logic                      bias_disable_request = 1'b0, fault_read = 1'b0;
  logic                      watchdog_expire = 1'b0, safety_timer_expire = 1'b0;
  logic                      charge_enable = 1'b1, push_button_input_n = 1'b1;
  logic                      general_output_function = 1'b1;
  logic [2:0]                thr_select = 3'h0, cool_zone_current_fraction = 3'h0;
  logic [tzfm_pkg::TS_W-1:0] thr_value = 10'h000, pack_mv = 10'h190;
  logic [7:0]                fast_charge_current_setting = 8'h00, battery_reg_setting = 8'h00;
  logic [7:0]                thermal_charge_setting = 8'h00;
  tzfm_pkg::tzfm_ts_mode_t   ts_mode = tzfm_pkg::TS_FOUR_ZONE;
  tzfm_pkg::tzfm_pg_mode_t   pg_mode = tzfm_pkg::PG_SUPPLY;
  logic [tzfm_pkg::TS_W-1:0] thermistor_sense_input, ts_voltage_out;
  logic [7:0]                charge_current_out, reg_voltage_out;
  tzfm_pkg::tzfm_zone_t      ts_zone_out;
  logic                      ts_bias_enable, charge_allow, safety_timer_run, interrupt_pulse;
  logic                      ts_voltage_valid, thermistor_open_flag, thermistor_cold_flag;
  logic                      thermistor_cool_flag, thermistor_warm_flag, thermistor_hot_flag;
  logic                      watchdog_expired_flag, safety_timer_expired_flag;
  logic                      button_wake_one_flag, button_wake_two_flag;
  logic                      button_reset_warning_flag, supply_valid_out, supply_valid_out_oe;
  logic [tzfm_pkg::FLAG_N-1:0] flg;
  int                        thr [tzfm_pkg::THR_N] = '{900, 585, 514, 265, 185};
  int                        tm [NS] = '{0, 0, 0, 0, 0, 0, 1, 1, 2, 2, 0, 0};
  int                        tv [NS] = '{400, 950, 600, 550, 200, 100, 550, 100, 100, 950, 400, 550};
  int                        seed = 26, err_count = 0, cmp_count = 0;

  assign flg = {button_reset_warning_flag, button_wake_two_flag, button_wake_one_flag,
                safety_timer_expired_flag, watchdog_expired_flag, thermistor_hot_flag,
                thermistor_warm_flag, thermistor_cool_flag, thermistor_cold_flag,
                thermistor_open_flag};
  always #2.5 clk = ~clk;

  tzfm_monitor #(.BURST_US(BUS), .PERIOD_US(PUS), .WAKE1_MS(2), .WAKE2_MS(3), .RWARN_MS(4))
    i_tzfm_monitor (
    .clk, .sys_rst, .supply_present, .battery_present, .thermistor_sense_input,
    .bias_disable_request, .ts_mode, .thr_write, .thr_select, .thr_value, .watchdog_expire,
    .safety_timer_expire, .charge_enable, .push_button_input_n, .fault_read, .pg_mode,
    .general_output_function, .fast_charge_current_setting, .cool_zone_current_fraction,
    .battery_reg_setting, .thermal_charge_setting, .ts_bias_enable, .charge_allow,
    .safety_timer_run, .charge_current_out, .reg_voltage_out, .interrupt_pulse,
    .ts_voltage_out, .ts_voltage_valid, .ts_zone_out, .thermistor_open_flag,
    .thermistor_cold_flag, .thermistor_cool_flag, .thermistor_warm_flag, .thermistor_hot_flag,
    .watchdog_expired_flag, .safety_timer_expired_flag, .button_wake_one_flag,
    .button_wake_two_flag, .button_reset_warning_flag, .supply_valid_out, .supply_valid_out_oe
  );
  tzfm_partner i_tzfm_partner (.clk, .ts_bias_enable, .pack_mv, .thermistor_sense_input);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic int xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic tzfm_pkg::tzfm_zone_t zone_of(int v);
    if (v > thr[0]) return tzfm_pkg::ZONE_OPEN;
    if (v > thr[1]) return tzfm_pkg::ZONE_COLD;
    if (v > thr[2]) return tzfm_pkg::ZONE_COOL;
    if (v < thr[4]) return tzfm_pkg::ZONE_HOT;
    if (v < thr[3]) return tzfm_pkg::ZONE_WARM;
    return tzfm_pkg::ZONE_NORMAL;
  endfunction : zone_of
  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic final_report();
    if (err_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report
  task automatic rd();
    fault_read = 1'b1;
    cyc(1);
    fault_read = 1'b0;
    cyc(1);
  endtask : rd
  task automatic thr_wr(input logic [2:0] s, input logic [9:0] v);
    thr_write = 1'b1;
    thr_select = s;
    thr_value = v;
    cyc(1);
    thr_write = 1'b0;
    cyc(1);
  endtask : thr_wr
  task automatic bias_count(output int n);
    n = 0;
    repeat (PER) begin
      @(negedge clk);
      n += ts_bias_enable;
    end
  endtask : bias_count

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    int r, n, fs, fr, cur;
    bit four, stop;
    tzfm_pkg::tzfm_zone_t z, pz;
    cyc(10);
    chk(interrupt_pulse, 0);
    chk(flg, 0);
    chk(ts_zone_out, tzfm_pkg::ZONE_NORMAL);
    sys_rst = 1'b0;
    for (int i = 0; i < 12; i++) begin
      r = xs();
      pg_mode = tzfm_pkg::tzfm_pg_mode_t'(i % 3);
      general_output_function = r[0];
      push_button_input_n = r[1];
      supply_present = r[2];
      battery_present = r[3];
      cyc(2);
      chk(supply_valid_out_oe, (i % 3 == 0) ? r[2] : (i % 3 == 1) ? !r[0] : !r[1]);
      chk(supply_valid_out, 0);
      chk(ts_voltage_valid, r[2] | r[3]);
    end
    pg_mode = tzfm_pkg::PG_SUPPLY;
    push_button_input_n = 1'b1;
    supply_present = 1'b1;
    battery_present = 1'b1;
    bias_disable_request = 1'b1;
    bias_count(n);
    chk(n, BUS * tzfm_pkg::TICK_CYCLES);
    supply_present = 1'b0;
    bias_count(n);
    chk(n, 0);
    supply_present = 1'b1;
    bias_disable_request = 1'b0;
    pz = tzfm_pkg::ZONE_NORMAL;
    for (int i = 0; i < NS; i++) begin
      if (i == NS - 1) begin
        thr_wr(3'h5, 10'h000);
        thr_wr(tzfm_pkg::THR_COOL, 10'h230);
        thr[2] = 560;
      end
      r = xs();
      fs = r[7:0];
      fr = r[10:8];
      fast_charge_current_setting = r[7:0];
      cool_zone_current_fraction = r[10:8];
      battery_reg_setting = r[18:11];
      thermal_charge_setting = r[26:19];
      ts_mode = tzfm_pkg::tzfm_ts_mode_t'(tm[i]);
      pack_mv = tv[i][9:0];
      rd();
      cyc(PER + 50);
      z = zone_of(tv[i]);
      four = tm[i] == 0;
      stop = z == tzfm_pkg::ZONE_OPEN || (tm[i] < 2 &&
             (z == tzfm_pkg::ZONE_COLD || z == tzfm_pkg::ZONE_HOT));
      cur = (four && z == tzfm_pkg::ZONE_COOL) ?
            (fs * (int'(tzfm_pkg::FRAC_ONE) - fr)) >> tzfm_pkg::FRAC_SHIFT : fs;
      chk(charge_allow, !stop);
      chk(charge_current_out, cur);
      chk(reg_voltage_out, (four && z == tzfm_pkg::ZONE_WARM) ? r[26:19] : r[18:11]);
      chk(ts_voltage_out, tv[i]);
      if (stop && z != tzfm_pkg::ZONE_OPEN)
        chk(safety_timer_run, 0);
      if (four)
        chk(ts_zone_out, z);
      if (four)
        chk(flg, (z != pz && z != tzfm_pkg::ZONE_NORMAL) ? 1 << (int'(z) - 1) : 0);
      if (z != pz)
        chk(interrupt_pulse, 1);
      pz = z;
    end
    rd();
    watchdog_expire = 1'b1;
    cyc(2);
    chk(watchdog_expired_flag, 1);
    chk(charge_allow, 1);
    n = 2;
    while (interrupt_pulse === 1'b1 && n < 26000) begin
      cyc(1);
      n++;
    end
    if (n >= 26000)
      err_count++;
    chk(n >= 25590 && n <= 25810, 1);
    safety_timer_expire = 1'b1;
    cyc(2);
    chk(safety_timer_expired_flag, 1);
    chk(charge_allow, 0);
    chk(safety_timer_run, 0);
    rd();
    chk(charge_allow, 0);
    charge_enable = 1'b0;
    cyc(2);
    charge_enable = 1'b1;
    cyc(2);
    chk(charge_allow, 1);
    chk(safety_timer_run, 1);
    chk(safety_timer_expired_flag, 0);
    final_report();
  end
endmodule : tzfm_monitor_tb

// ==== tb/tzfm_partner.sv ====
// Battery pack thermistor seen through the bias switch
`timescale 1ns/10ps
module tzfm_partner (
  input  wire logic                      clk,
  input  wire logic                      ts_bias_enable,
  input  wire logic [tzfm_pkg::TS_W-1:0] pack_mv,
  output logic      [tzfm_pkg::TS_W-1:0] thermistor_sense_input
);
  // ****************************************
  // Pin level, toggling while unbiased
  // ****************************************
  initial thermistor_sense_input = 10'h000;
  always @(posedge clk) begin
    if (ts_bias_enable)
      thermistor_sense_input <= pack_mv;
    else
      thermistor_sense_input <= ~thermistor_sense_input;
  end
endmodule : tzfm_partner
